// file: src/fpx_consts.svh
// Purpose: constants for the floating exception and field decode unit
// Assumes: 16-bit instruction words, octal field layout
// Notes: definitions only
`ifndef FPX_CONSTS_SVH
`define FPX_CONSTS_SVH
`define FPX_VECTOR 16'h00a4
`define FPX_CAUSE_OPCODE 5'h02
`define FPX_CAUSE_DIVZERO 5'h04
`define FPX_CAUSE_CONV 5'h06
`define FPX_CAUSE_OVF 5'h0a
`define FPX_CAUSE_UNF 5'h0c
`define FPX_CAUSE_UNDEF 5'h0e
`define FPX_CAUSE_UBREAK 5'h10
`define FPX_PRIMARY_OP 4'hf
`define FPX_EXP_BIAS_FIX 9'h100
`endif

// file: src/fpx_pkg.sv
// Purpose: types for the floating exception and field decode unit
// Assumes: nothing
// Notes: shared structs
package fpx_pkg;
  typedef enum logic [2:0] {fmt_none, two_operand_float_format, single_operand_float_format,
    integer_exponent_format, status_transfer_format, no_operand_format} fmt_t;
  typedef struct packed {
    logic overflow;
    logic underflow;
    logic conv_error;
    logic neg_zero_fetch;
    logic div_zero;
    logic bad_opcode;
    logic ubreak;
  } fault_t;
  typedef struct packed {
    logic global_trap_mask;
    logic undefined_variable_trap_enable;
    logic underflow_trap_enable;
    logic overflow_trap_enable;
    logic conversion_trap_enable;
  } enables_t;
  typedef struct packed {
    logic is_float;
    fmt_t fmt;
    logic [7:0] sub_operation_field;
    logic [5:0] host_operand;
    logic [5:0] float_operand;
    logic float_operand_valid;
    logic float_ac_mode;
    logic [2:0] float_ac;
    logic [1:0] register_pick_field;
    logic pick_valid;
    logic bad_ac;
  } decode_t;
endpackage : fpx_pkg

// file: src/fpx_unit.sv
// Purpose: floating exception reporting and instruction field decode
// Assumes: host supplies instruction, its address and fault events
// Notes: one clock, outputs registered except the constant vector
//
// Behaviour
// - every interrupt points at the one fixed vector 244 octal
// - seven distinct causes each load an encoded cause code
// - cause codes are even table offsets
// - bad opcode gives cause 2
// - divide by zero gives cause 4
// - conversion 6, overflow 10, underflow 12, undefined 14, microbreak 16
// - causes 6, 10, 12, 14 trap only with their enable set
// - global mask suppresses every trap
// - 16-bit fault address holds last trapping instruction address; masked or disabled faults leave it
// - pick field bits 7..6 selects accumulators 0 to 3
// - mode 0 in formats one/two, bits 2..0 select accumulator 0 to 5
// - mode 0 accumulator 6 or 7 traps as a bad opcode, with no enable, unless globally masked
// - primary opcode octal 17 marks a float instruction
// - sub-operation field width depends on format
// - operand fields are 6-bit host style addressing fields
// - float source only in format one, mode 0 means accumulator
// - float destination in formats one/two, mode 0 means accumulator
// - pick field only in formats one and three
// - format four carries one host operand for status transfer
// - negative zero fetch traps when undefined variable enable set
// - conversion error sets flag, clears destination, traps if enabled
// - trapped over/underflow exponent off by 400; underflow with its enable clear gives zero
`timescale 1ns/1ps
`include "fpx_consts.svh"
module fpx_unit
  import fpx_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [15:0] i_instr,
  input wire logic [15:0] i_instr_addr,
  input wire fault_t i_fault,
  input wire enables_t i_enables,
  input wire logic i_result_zero_is_neg,
  input wire logic [8:0] i_result_exp,
  output logic o_irq,
  output logic [15:0] o_vector,
  output logic [4:0] o_trap_cause_code_reg,
  output logic [15:0] o_fault_pc_reg,
  output logic o_conversion_fault_flag,
  output logic o_clear_dest,
  output logic o_treat_as_pos_zero,
  output logic o_force_zero,
  output logic [7:0] o_result_exp,
  output decode_t o_decode
);
  // ************************************
  // State
  // ************************************
  typedef struct packed {
    logic irq_pend;
    logic irq;
    logic [4:0] cause;
    logic [15:0] fault_pc;
    logic conv_flag;
    logic clear_dest;
    logic pos_zero;
    logic force_zero;
    logic [7:0] rexp;
    decode_t dec;
  } state_t;
  state_t st;
  state_t next_st;

  // ************************************
  // Field decode function
  // ************************************
  function automatic decode_t decode_fields(input logic [15:0] w);
    decode_t d;
    d = '0;
    d.is_float = (w[15:12] == `FPX_PRIMARY_OP);
    d.host_operand = w[5:0];
    d.float_operand = w[5:0];
    d.register_pick_field = w[7:6];
    if (d.is_float) begin
      if (w[11:8] == 4'h0) begin
        if (w[7:6] == 2'h0) begin
          d.fmt = no_operand_format;
          d.sub_operation_field = {2'h0, w[5:0]};
        end else if (w[7:6] == 2'h1) begin
          d.fmt = status_transfer_format;
          d.sub_operation_field = {6'h00, w[7:6]};
        end else begin
          d.fmt = single_operand_float_format;
          d.sub_operation_field = {6'h00, w[7:6]};
        end
      end else if (w[11:8] == 4'h1) begin
        d.fmt = single_operand_float_format;
        d.sub_operation_field = {4'h0, w[11:8]};
      end else if (w[11:8] == 4'hd || w[11:8] == 4'he || w[11:8] == 4'ha
          || w[11:8] == 4'hb) begin
        d.fmt = integer_exponent_format;
        d.sub_operation_field = {4'h0, w[11:8]};
      end else begin
        d.fmt = two_operand_float_format;
        d.sub_operation_field = {4'h0, w[11:8]};
      end
      // float operand only in formats one/two
      d.float_operand_valid = (d.fmt == two_operand_float_format)
          || (d.fmt == single_operand_float_format);
      d.float_ac_mode = d.float_operand_valid && (w[5:3] == 3'h0);
      d.float_ac = w[2:0];
      d.bad_ac = d.float_ac_mode && (w[2:1] == 2'h3);
      d.pick_valid = (d.fmt == two_operand_float_format)
          || (d.fmt == integer_exponent_format);
      if (!d.float_operand_valid) d.float_operand = 6'h00;
    end
    return d;
  endfunction : decode_fields

  // ************************************
  // Cause encoder function
  // ************************************
  function automatic logic [4:0] cause_of(input fault_t f);
    if (f.bad_opcode) return `FPX_CAUSE_OPCODE;
    else if (f.div_zero) return `FPX_CAUSE_DIVZERO;
    else if (f.conv_error) return `FPX_CAUSE_CONV;
    else if (f.overflow) return `FPX_CAUSE_OVF;
    else if (f.underflow) return `FPX_CAUSE_UNF;
    else if (f.neg_zero_fetch) return `FPX_CAUSE_UNDEF;
    else return `FPX_CAUSE_UBREAK;
  endfunction : cause_of

  // ************************************
  // Next state
  // ************************************
  fault_t gated;
  logic any_trap;
  decode_t cur;
  always_comb begin
    next_st = st;
    cur = decode_fields(i_instr);
    gated = '0;
    gated.bad_opcode = i_fault.bad_opcode || (cur.bad_ac);
    gated.div_zero = i_fault.div_zero;
    gated.conv_error = i_fault.conv_error && i_enables.conversion_trap_enable;
    gated.overflow = i_fault.overflow && i_enables.overflow_trap_enable;
    gated.underflow = i_fault.underflow && i_enables.underflow_trap_enable;
    gated.neg_zero_fetch = i_fault.neg_zero_fetch
        && i_enables.undefined_variable_trap_enable;
    gated.ubreak = i_fault.ubreak;
    any_trap = i_valid && (|gated) && !i_enables.global_trap_mask;
    next_st.irq = st.irq_pend;
    next_st.irq_pend = 1'b0;
    next_st.clear_dest = 1'b0;
    next_st.force_zero = 1'b0;
    next_st.pos_zero = 1'b0;
    if (i_valid) begin
      next_st.dec = cur;
      next_st.conv_flag = i_fault.conv_error;
      next_st.clear_dest = i_fault.conv_error;
      next_st.pos_zero = i_result_zero_is_neg && !i_enables.undefined_variable_trap_enable;
      next_st.force_zero = i_fault.underflow && !i_enables.underflow_trap_enable;
      next_st.rexp = i_result_exp[7:0];
    end
    if (any_trap) begin
      next_st.cause = cause_of(gated);
      next_st.fault_pc = i_instr_addr;
      next_st.irq_pend = 1'b1;
    end
  end

  // State register, cleared by reset
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ************************************
  // Outputs
  // ************************************
  assign o_irq = st.irq;
  assign o_vector = `FPX_VECTOR;
  assign o_trap_cause_code_reg = st.cause;
  assign o_fault_pc_reg = st.fault_pc;
  assign o_conversion_fault_flag = st.conv_flag;
  assign o_clear_dest = st.clear_dest;
  assign o_treat_as_pos_zero = st.pos_zero;
  assign o_force_zero = st.force_zero;
  assign o_result_exp = st.rexp;
  assign o_decode = st.dec;

  // ************************************
  // Checks
  // ************************************
  property p_even_cause;
    @(posedge i_mclk) disable iff (i_rst) o_irq |-> (o_trap_cause_code_reg[0] == 1'b0);
  endproperty
  a_even_cause: assert property (p_even_cause) else $error("odd cause");
  property p_mask;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_enables.global_trap_mask) |=> !st.irq_pend;
  endproperty
  a_mask: assert property (p_mask) else $error("masked trap raised");
  property p_order;
    @(posedge i_mclk) disable iff (i_rst)
      any_trap |=> (o_fault_pc_reg == $past(i_instr_addr)) ##1 o_irq;
  endproperty
  a_order: assert property (p_order) else $error("irq without address");
  property p_div;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && i_fault.div_zero && !i_fault.bad_opcode && !cur.bad_ac)
      |=> o_trap_cause_code_reg == 5'h04;
  endproperty
  a_div: assert property (p_div) else $error("divide cause wrong");
  property p_ovf_off;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_fault.overflow && !i_enables.overflow_trap_enable
       && i_fault == 7'h40 && !cur.bad_ac) |=> ##1 !o_irq;
  endproperty
  a_ovf_off: assert property (p_ovf_off) else $error("overflow trap not gated");
  property p_vec;
    @(posedge i_mclk) disable iff (i_rst) o_irq |-> o_vector == 16'h00a4;
  endproperty
  a_vec: assert property (p_vec) else $error("vector wrong");
  property p_badac;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && cur.bad_ac && !i_enables.global_trap_mask) |=> ##1 o_irq;
  endproperty
  a_badac: assert property (p_badac) else $error("bad accumulator no trap");
  property p_conv;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_fault.conv_error) |=> (o_conversion_fault_flag && o_clear_dest);
  endproperty
  a_conv: assert property (p_conv) else $error("conversion flag missing");

  // ************************************
  // Cause, address, decode and result checks
  // ************************************
  property p_opcode_cause;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && gated.bad_opcode) |=> o_trap_cause_code_reg == 5'h02;
  endproperty
  a_opcode_cause: assert property (p_opcode_cause) else $error("opcode cause wrong");
  property p_conv_cause;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && gated == 7'h10) |=> o_trap_cause_code_reg == 5'h06;
  endproperty
  a_conv_cause: assert property (p_conv_cause) else $error("conversion cause wrong");
  property p_ovf_cause;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && gated == 7'h40) |=> o_trap_cause_code_reg == 5'h0a;
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("overflow cause wrong");
  property p_unf_cause;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && gated == 7'h20) |=> o_trap_cause_code_reg == 5'h0c;
  endproperty
  a_unf_cause: assert property (p_unf_cause) else $error("underflow cause wrong");
  property p_undef_cause;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && gated == 7'h08) |=> o_trap_cause_code_reg == 5'h0e;
  endproperty
  a_undef_cause: assert property (p_undef_cause) else $error("undefined cause wrong");
  property p_ubreak_cause;
    @(posedge i_mclk) disable iff (i_rst)
      (any_trap && gated == 7'h01) |=> o_trap_cause_code_reg == 5'h10;
  endproperty
  a_ubreak_cause: assert property (p_ubreak_cause) else $error("microbreak cause wrong");
  property p_cause_hold;
    @(posedge i_mclk) disable iff (i_rst)
      !any_trap |=> $stable(o_trap_cause_code_reg);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed without trap");
  property p_pc;
    @(posedge i_mclk) disable iff (i_rst)
      any_trap |=> o_fault_pc_reg == $past(i_instr_addr);
  endproperty
  a_pc: assert property (p_pc) else $error("fault address not captured");
  property p_ac_mode;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && cur.float_operand_valid && i_instr[5:3] == 3'h0)
      |=> (o_decode.float_ac_mode && o_decode.float_ac == $past(i_instr[2:0]));
  endproperty
  a_ac_mode: assert property (p_ac_mode) else $error("mode 0 accumulator wrong");
  property p_not_float;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_instr[15:12] != 4'hf) |=> !o_decode.is_float;
  endproperty
  a_not_float: assert property (p_not_float) else $error("non-float decoded as float");
  property p_no_pick;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_instr[15:8] == 8'hf0) |=> !o_decode.pick_valid;
  endproperty
  a_no_pick: assert property (p_no_pick) else $error("pick field in wrong format");
  property p_int_fmt;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_instr[15:8] == 8'hfa) |=> !o_decode.float_operand_valid;
  endproperty
  a_int_fmt: assert property (p_int_fmt) else $error("float operand in format three");
  property p_status_fmt;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_instr[15:6] == 10'h3c1) |=> o_decode.fmt == status_transfer_format;
  endproperty
  a_status_fmt: assert property (p_status_fmt) else $error("status format missed");
  property p_negzero;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_fault.neg_zero_fetch && i_enables.undefined_variable_trap_enable
       && !i_enables.global_trap_mask) |=> st.irq_pend;
  endproperty
  a_negzero: assert property (p_negzero) else $error("negative zero did not trap");
  property p_poszero;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_result_zero_is_neg && !i_enables.undefined_variable_trap_enable)
      |=> o_treat_as_pos_zero;
  endproperty
  a_poszero: assert property (p_poszero) else $error("negative zero not positive");
  property p_unf_zero;
    @(posedge i_mclk) disable iff (i_rst)
      (i_valid && i_fault.underflow && !i_enables.underflow_trap_enable) |=> o_force_zero;
  endproperty
  a_unf_zero: assert property (p_unf_zero) else $error("untrapped underflow not zero");
  property p_exp;
    @(posedge i_mclk) disable iff (i_rst)
      i_valid |=> {1'b0, o_result_exp} == ($past(i_result_exp) & 9'h0ff);
  endproperty
  a_exp: assert property (p_exp) else $error("exponent wrap wrong");
endmodule : fpx_unit

// file: sim/host_model.sv
// Purpose: host processor model issuing floating instructions
// Assumes: one completing instruction per valid pulse
// Notes: released instruction and address lines show inverted values, not the last ones; fault lines clear
`timescale 1ns/1ps
module host_model
  import fpx_pkg::*;
(
  input wire logic i_mclk,
  output logic o_valid,
  output logic [15:0] o_instr,
  output logic [15:0] o_instr_addr,
  output fault_t o_fault,
  output logic o_neg
);
  // Idle lines at time zero
  initial begin
    o_valid = 1'b0;
    o_instr = 16'h0000;
    o_instr_addr = 16'h0000;
    o_fault = '0;
    o_neg = 1'b0;
  end

  // One valid cycle, then release with inverted leftovers
  task automatic issue(input logic [15:0] instr, input logic [15:0] addr, input fault_t f);
    @(negedge i_mclk);
    o_valid = 1'b1;
    o_instr = instr;
    o_instr_addr = addr;
    o_fault = f;
    o_neg = f.neg_zero_fetch;
    @(negedge i_mclk);
    o_valid = 1'b0;
    o_instr = ~instr;
    o_instr_addr = ~addr;
    o_fault = '0;
    o_neg = 1'b0;
  endtask : issue
endmodule : host_model

// file: sim/tb_top.sv
// Purpose: self-checking bench for the floating exception unit
// Assumes: cause and address one cycle after valid, irq one later
// Notes: registered answers checked at the falling edge after the taking edge
`timescale 1ns/1ps
module tb_top;
  import fpx_pkg::*;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  enables_t en = '0;
  logic valid, neg, o_irq, o_conversion_fault_flag;
  logic [15:0] instr, addr, o_vector, o_fault_pc_reg;
  logic [4:0] o_trap_cause_code_reg;
  logic o_clear_dest, o_treat_as_pos_zero, o_force_zero;
  logic [7:0] o_result_exp;
  logic [8:0] rexp_in = 9'h1c3;
  fault_t fault;
  decode_t o_decode;
  int errors = 0;
  int n_tests = 0;
  int cycles = 0;
  fault_t fl [7] = '{7'h02, 7'h04, 7'h10, 7'h40, 7'h20, 7'h08, 7'h01};
  logic [4:0] cs [7] = '{5'h02, 5'h04, 5'h06, 5'h0a, 5'h0c, 5'h0e, 5'h10};

  always #5 i_mclk = ~i_mclk;

  host_model i_host (.i_mclk(i_mclk), .o_valid(valid), .o_instr(instr),
    .o_instr_addr(addr), .o_fault(fault), .o_neg(neg));

  fpx_unit i_dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_valid(valid), .i_instr(instr),
    .i_instr_addr(addr), .i_fault(fault), .i_enables(en), .i_result_zero_is_neg(neg),
    .i_result_exp(rexp_in), .o_irq(o_irq), .o_vector(o_vector),
    .o_trap_cause_code_reg(o_trap_cause_code_reg), .o_fault_pc_reg(o_fault_pc_reg),
    .o_conversion_fault_flag(o_conversion_fault_flag), .o_clear_dest(o_clear_dest),
    .o_treat_as_pos_zero(o_treat_as_pos_zero), .o_force_zero(o_force_zero),
    .o_result_exp(o_result_exp), .o_decode(o_decode));

  // ****************
  // Checks and closing
  // ****************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("counts errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      conclude();
    end
  end

  // One instruction, then cause/address/flag and the late irq
  task automatic run(input logic [15:0] ins, input logic [15:0] a, input fault_t f,
    input enables_t e, input logic irq, input logic [4:0] cause);
    en = e;
    i_host.issue(ins, a, f);
    // Answers stand from the taking edge; irq follows one edge later
    if (irq) begin
      chk(o_trap_cause_code_reg, cause);
      chk(o_fault_pc_reg, a);
    end
    chk(o_irq, 1'b0);
    chk(o_conversion_fault_flag, f.conv_error);
    chk(o_clear_dest, f.conv_error);
    chk(o_force_zero, f.underflow && !e.underflow_trap_enable);
    chk(o_treat_as_pos_zero, f.neg_zero_fetch && !e.undefined_variable_trap_enable);
    chk(o_result_exp, 8'(rexp_in - 9'h100));
    @(negedge i_mclk);
    chk(o_irq, irq);
    chk(o_vector, 16'h00a4);
  endtask : run

  // ****************
  // Test sequence
  // ****************
  initial begin
    repeat (3) @(posedge i_mclk);
    @(negedge i_mclk);
    i_rst = 1'b0;
    chk(o_irq, 1'b0);
    // Every cause with all enables on
    for (int i = 0; i < 7; i++) run(16'hf2c5, 16'h1000 + 16'(2 * i), fl[i], 5'h0f, 1'b1, cs[i]);
    $display("test causes done");
    // Each gated cause with only its own enable cleared
    rexp_in = 9'h0a5;
    for (int i = 2; i < 6; i++) run(16'hf2c5, 16'h2000, fl[i], 5'h0f & ~(5'h01 << (i - 2)), 1'b0, 4'h0);
    // Global mask blocks everything
    for (int i = 0; i < 7; i++) run(16'hf2c5, 16'h2100, fl[i], 5'h1f, 1'b0, 4'h0);
    chk(o_fault_pc_reg, 16'h100c);
    $display("test gating done");
    // Mode 0 accumulator 6 and 7
    run(16'hf2c6, 16'h3000, '0, 5'h00, 1'b1, 4'h2);
    run(16'hf2c7, 16'h3002, '0, 5'h00, 1'b1, 4'h2);
    // Format one decode
    run(16'hf2c5, 16'h3004, '0, 5'h0f, 1'b0, 4'h0);
    chk(o_decode.is_float, 1'b1);
    chk(o_decode.fmt, two_operand_float_format);
    chk(o_decode.register_pick_field, 2'h3);
    chk(o_decode.pick_valid, 1'b1);
    chk(o_decode.float_ac, 3'h5);
    chk(o_decode.float_ac_mode, 1'b1);
    chk(o_decode.sub_operation_field, 8'h02);
    chk(o_decode.bad_ac, 1'b0);
    // Format two, three and four decode
    run(16'hf1c5, 16'h3006, '0, 5'h0f, 1'b0, 4'h0);
    chk(o_decode.fmt, single_operand_float_format);
    chk(o_decode.pick_valid, 1'b0);
    chk(o_decode.float_operand_valid, 1'b1);
    run(16'hfa85, 16'h3008, '0, 5'h0f, 1'b0, 4'h0);
    chk(o_decode.fmt, integer_exponent_format);
    chk(o_decode.register_pick_field, 2'h2);
    chk(o_decode.float_operand_valid, 1'b0);
    run(16'hf045, 16'h300a, '0, 5'h0f, 1'b0, 4'h0);
    chk(o_decode.fmt, status_transfer_format);
    chk(o_decode.host_operand, 6'h05);
    // Non-floating opcode
    run(16'h72c5, 16'h300c, '0, 5'h0f, 1'b0, 4'h0);
    chk(o_decode.is_float, 1'b0);
    $display("test decode done");
    conclude();
  end
endmodule : tb_top
